// ---- logic/acsf_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carrier types of the command sequencer and data FIFO
// Assumes: 32-bit APB register access, one shared word-addressed SRAM
// Notes:   all offsets are byte addresses
//////////////////////////////////////////////////////////////////////////////
package acsf_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_SEQ_CONFIG  = 16'h2004;
    localparam logic [15:0] ADDR_FIFO_CONFIG = 16'h2008;
    localparam logic [15:0] ADDR_CMD_CRC     = 16'h2060;
    localparam logic [15:0] ADDR_CMD_COUNT   = 16'h2064;
    localparam logic [15:0] ADDR_TMO_COUNT   = 16'h2068;
    localparam logic [15:0] ADDR_FIFO_READ   = 16'h206C;
    localparam logic [15:0] ADDR_CMD_WRITE   = 16'h2070;
    localparam logic [15:0] ADDR_SEQ_DESC0   = 16'h21CC;
    localparam logic [15:0] ADDR_SEQ_DESC2   = 16'h21D0;
    localparam logic [15:0] ADDR_CMD_WADDR   = 16'h21D4;
    localparam logic [15:0] ADDR_MEM_CTRL    = 16'h21D8;
    localparam logic [15:0] ADDR_FIFO_THRES  = 16'h21E0;
    localparam logic [15:0] ADDR_SEQ_DESC3   = 16'h21E4;
    localparam logic [15:0] ADDR_SEQ_DESC1   = 16'h21E8;
    localparam logic [15:0] ADDR_FIFO_STAT   = 16'h2200;
    localparam logic [15:0] ADDR_SEQ_TRIG    = 16'h2300;
    localparam logic [15:0] ADDR_FLAG        = 16'h2304;
    localparam logic [15:0] ADDR_FLAG_CLR    = 16'h2308;
    localparam logic [15:0] ADDR_FLAG_MASK   = 16'h230C;
    localparam logic [15:0] MMR_BASE         = 16'h2000;
    // reset values and writable masks
    localparam logic [31:0] SEQCFG_RST  = 32'h00000002;
    localparam logic [31:0] SEQCFG_MASK = 32'h0000FFFF;
    localparam logic [31:0] FIFOCFG_RST = 32'h00001010;
    localparam logic [31:0] FIFOCFG_MASK = 32'h0000FFFF;
    localparam logic [31:0] MEMCTL_RST  = 32'h00000410;
    localparam logic [31:0] MEMCTL_MASK = 32'h00000FFF;
    localparam logic [31:0] DESC_MASK   = 32'h07FF07FF;
    localparam logic [31:0] FLAGS_MASK  = 32'h0C000007;
    // fields
    localparam int RUN_BIT = 0;
    localparam int PWD_LSB = 8;
    localparam int FIFO_EN_BIT = 11;
    localparam int SRC_LSB = 13;
    localparam int CMD_SIZE_LSB = 0;
    localparam int DATA_SIZE_LSB = 6;
    localparam int DATA_MODE_LSB = 9;
    localparam int DESC_CNT_LSB = 16;
    localparam int FSTAT_CNT_LSB = 16;
    localparam int CMD_WR_BIT = 31;
    localparam int CMD_TMO_BIT = 30;
    localparam int CMD_ADDR_LSB = 24;
    localparam int FLG_END_SEQ = 15;
    localparam int FLG_TMO_FIN = 16;
    localparam int FLG_TMO_ERR = 17;
    localparam int FLG_OVF = 26;
    localparam int FLG_UDF = 27;
    localparam logic [2:0]  MODE_STREAM = 3'h3;
    localparam logic [2:0]  NUM_SRC     = 3'h5;
    localparam logic [7:0]  CRC_SEED    = 8'h01;
    localparam logic [7:0]  CRC_POLY    = 8'h07;
    localparam logic [10:0] WORDS_2K    = 11'h200;
    localparam logic [10:0] WORDS_4K    = 11'h400;
    localparam logic [10:0] WORDS_6K    = 11'h600;
    localparam int MEM_WORDS = 1536;

    typedef enum logic [1:0] {S_IDLE = 2'b00, S_RUN = 2'b01, S_WAIT = 2'b10} acsf_state_t;
    typedef struct packed { logic valid; logic [31:0] data; } acsf_src_t;
    typedef struct packed { logic valid; logic [15:0] addr; logic [31:0] data; } acsf_mmr_wr_t;
    typedef struct packed {
        logic endSeq; logic tmoFinished; logic tmoError;
        logic fifoEmpty; logic fifoFull; logic fifoThresh; logic fifoOverflow; logic fifoUnderflow;
    } acsf_flags_t;
endpackage : acsf_pkg

// ---- logic/acsf_sequencer.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: command sequencer, shared command SRAM and measurement data FIFO
// Assumes: APB slave with zero wait states, sources present one word per pulse
// Notes:   one clock runs all timers; no interrupt controller inside
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

// Function
// - command word with top bit set is a register write with address and data
// - each register write command completes in one execution cycle
// - seven-bit address field maps onto target address bits 8 to 2
// - 24 data bits go to register bits 23 to 0; top byte written as zero
// - sequencer register accesses are full 32-bit writes only
// - wait and timeout have own counters; wait stalls until zero
// - timeout counter runs independently and raises timeout-finished at expiry
// - timeout expiring before sequence end also raises timeout-error
// - timeout flags stay set until host writes the clear register
// - timeout count survives self stop, resets on host run-bit zero, readable
// - timers count clock periods regardless of post-write delay
// - command memory size selected 2, 4 or 6 kB by control bits 2-0
// - four descriptors hold count in bits 26-16, start in 10-0
// - end-of-sequence only when final command clears config bit 0
// - data FIFO sized 2, 4 or 6 kB in same SRAM; software avoids overlap
// - bits 11-9 pick stream (drop oldest) or FIFO (drop new) when full
// - FIFO config bits 15-13 select which source writes the FIFO
// - empty, full, threshold, overflow, underflow flags; last two one-cycle pulses
// - FIFO enable bit 11, own threshold register, count in status bits 26-16
// - read of empty FIFO returns zero and pulses underflow flag 27
// - post-write delay after write commands only, not after timer commands
// - run bit one enables, zero disables; strictly sequential execution
// - CRC-8 seed 0x01 per executed command; count-register write resets both
module acsf_sequencer
    import acsf_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [15:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire acsf_src_t [4:0]  srcIn,
    output acsf_mmr_wr_t          mmrWr,
    output acsf_flags_t           flags,
    output logic                  seqBusy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    function automatic logic [10:0] sizeWords(input logic [2:0] code);
        case (code)
            3'h2:    sizeWords = WORDS_4K;
            3'h3:    sizeWords = WORDS_6K;
            default: sizeWords = WORDS_2K;
        endcase
    endfunction : sizeWords

    function automatic logic [7:0] crcNext(input logic [7:0] crc, input logic [31:0] d);
        logic [7:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        crcNext = c;
    endfunction : crcNext

    function automatic logic [10:0] wrapIdx(input logic [11:0] a);
        wrapIdx = (a >= 12'(MEM_WORDS)) ? 11'(a - 12'(MEM_WORDS)) : a[10:0];
    endfunction : wrapIdx

    logic [31:0]  mem_r [MEM_WORDS];
    logic [31:0]  seqCfg_r, fifoCfg_r, memCtl_r, thres_r, flagReg_r, mask_r;
    logic [31:0]  desc_r [4];
    logic [10:0]  cmdWaddr_r, pc_r, remain_r;
    logic [29:0]  waitCnt_r, tmoCnt_r;
    logic [15:0]  cmdCount_r;
    logic [7:0]   crc_r;
    logic [10:0]  fifoCnt_r, rdOff_r, wrOff_r;
    logic         ovf_r, udf_r;
    acsf_state_t  state_r;
    acsf_mmr_wr_t mmrWr_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic        apbWr, apbRd, hostRunOff, cntWrite, trigWrite;
    logic        selfCfgWr, exec, isWrite, isTimeout, isLast;
    logic [31:0] cmd, fifoWord;
    logic [31:0] flagSet, flagClr;
    logic        tmoExpire;
    logic [1:0]  trigIdx;
    assign apbWr      = psel && penable && pwrite;
    assign apbRd      = psel && penable && !pwrite;
    assign pready     = 1'b1;
    assign hostRunOff = apbWr && paddr == ADDR_SEQ_CONFIG && !pwdata[RUN_BIT];
    assign cntWrite   = apbWr && paddr == ADDR_CMD_COUNT;
    assign trigWrite  = apbWr && paddr == ADDR_SEQ_TRIG;
    assign trigIdx    = pwdata[1:0];
    assign flagClr    = (apbWr && paddr == ADDR_FLAG_CLR) ? pwdata : 32'h00000000;

    always_comb begin
        pslverr = 1'b0;
        prdata  = 32'h00000000;
        case (paddr)
            ADDR_SEQ_CONFIG:  prdata = seqCfg_r;
            ADDR_FIFO_CONFIG: prdata = fifoCfg_r;
            ADDR_CMD_CRC:     prdata = {24'h000000, crc_r};
            ADDR_CMD_COUNT:   prdata = {16'h0000, cmdCount_r};
            ADDR_TMO_COUNT:   prdata = {2'b00, tmoCnt_r};
            ADDR_FIFO_READ:   prdata = fifoWord;
            ADDR_CMD_WRITE:   prdata = 32'h00000000;
            ADDR_SEQ_DESC0:   prdata = desc_r[0];
            ADDR_SEQ_DESC1:   prdata = desc_r[1];
            ADDR_SEQ_DESC2:   prdata = desc_r[2];
            ADDR_SEQ_DESC3:   prdata = desc_r[3];
            ADDR_CMD_WADDR:   prdata = {21'h000000, cmdWaddr_r};
            ADDR_MEM_CTRL:    prdata = memCtl_r;
            ADDR_FIFO_THRES:  prdata = thres_r;
            ADDR_FIFO_STAT:   prdata = {5'h00, fifoCnt_r, 16'h0000};
            ADDR_SEQ_TRIG:    prdata = 32'h00000000;
            ADDR_FLAG:        prdata = flagReg_r;
            ADDR_FLAG_CLR:    prdata = 32'h00000000;
            ADDR_FLAG_MASK:   prdata = mask_r;
            default:          pslverr = psel && penable;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            fifoCfg_r  <= FIFOCFG_RST;
            memCtl_r   <= MEMCTL_RST;
            thres_r    <= 32'h00000000;
            mask_r     <= 32'h00000000;
            cmdWaddr_r <= 11'h000;
            for (int i = 0; i < 4; i++) desc_r[i] <= 32'h00000000;
        end else if (apbWr) begin
            case (paddr)
                ADDR_FIFO_CONFIG: fifoCfg_r  <= pwdata & FIFOCFG_MASK;
                ADDR_MEM_CTRL:    memCtl_r   <= pwdata & MEMCTL_MASK;
                ADDR_FIFO_THRES:  thres_r    <= {21'h000000, pwdata[10:0]};
                ADDR_FLAG_MASK:   mask_r     <= pwdata & FLAGS_MASK;
                ADDR_CMD_WADDR:   cmdWaddr_r <= pwdata[10:0];
                ADDR_SEQ_DESC0:   desc_r[0]  <= pwdata & DESC_MASK;
                ADDR_SEQ_DESC1:   desc_r[1]  <= pwdata & DESC_MASK;
                ADDR_SEQ_DESC2:   desc_r[2]  <= pwdata & DESC_MASK;
                ADDR_SEQ_DESC3:   desc_r[3]  <= pwdata & DESC_MASK;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    assign cmd       = mem_r[pc_r];
    assign exec      = state_r == S_RUN && seqCfg_r[RUN_BIT] && remain_r != 11'h000;
    assign isWrite   = cmd[CMD_WR_BIT];
    assign isTimeout = cmd[CMD_TMO_BIT];
    assign isLast    = remain_r == 11'h001;
    // writes aimed at the config register stay internal so the run bit can self-clear
    assign selfCfgWr = exec && isWrite && {cmd[30:24], 2'b00} == ADDR_SEQ_CONFIG[8:0];

    // sequencer writes win over a host write in the same cycle
    always_ff @(posedge clk) begin
        if (rst)
            seqCfg_r <= SEQCFG_RST;
        else if (selfCfgWr)
            seqCfg_r <= {16'h0000, cmd[15:0]};
        else if (apbWr && paddr == ADDR_SEQ_CONFIG)
            seqCfg_r <= pwdata & SEQCFG_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= S_IDLE;
            pc_r      <= 11'h000;
            remain_r  <= 11'h000;
            waitCnt_r <= 30'h00000000;
        end else if (!seqCfg_r[RUN_BIT] || hostRunOff) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (trigWrite) begin
                        pc_r     <= desc_r[trigIdx][10:0];
                        remain_r <= desc_r[trigIdx][DESC_CNT_LSB +: 11];
                        state_r  <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (remain_r == 11'h000) begin
                        state_r <= S_IDLE;
                    end else begin
                        pc_r     <= wrapIdx({1'b0, pc_r} + 12'h001);
                        remain_r <= remain_r - 11'h001;
                        if (selfCfgWr && !cmd[RUN_BIT]) begin
                            state_r <= S_IDLE;
                        end else if (isWrite) begin
                            waitCnt_r <= {22'h000000, seqCfg_r[PWD_LSB +: 8]};
                            if (seqCfg_r[PWD_LSB +: 8] != 8'h00) state_r <= S_WAIT;
                        end else if (!isTimeout && cmd[29:0] != 30'h00000000) begin
                            waitCnt_r <= cmd[29:0];
                            state_r   <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    waitCnt_r <= waitCnt_r - 30'h00000001;
                    if (waitCnt_r == 30'h00000001) state_r <= S_RUN;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
    assign seqBusy = state_r != S_IDLE;

    // register writes leave in the cycle after execution, as one full word
    always_ff @(posedge clk) begin
        if (rst) begin
            mmrWr_r <= '0;
        end else begin
            mmrWr_r.valid <= exec && isWrite && !selfCfgWr;
            mmrWr_r.addr  <= MMR_BASE | {7'h00, cmd[CMD_ADDR_LSB +: 7], 2'b00};
            mmrWr_r.data  <= {8'h00, cmd[23:0]};
        end
    end
    assign mmrWr = mmrWr_r;

    ////////////////////////////////////////////////////////////////////////////
    // count, CRC and timeout
    always_ff @(posedge clk) begin
        if (rst || cntWrite) begin
            cmdCount_r <= 16'h0000;
            crc_r      <= CRC_SEED;
        end else if (exec) begin
            cmdCount_r <= cmdCount_r + 16'h0001;
            crc_r      <= crcNext(crc_r, cmd);
        end
    end

    // keeps running through a self stop; only the host clearing the run bit zeroes it
    assign tmoExpire = tmoCnt_r == 30'h00000001 && !hostRunOff;
    always_ff @(posedge clk) begin
        if (rst || hostRunOff)
            tmoCnt_r <= 30'h00000000;
        else if (exec && !isWrite && isTimeout)
            tmoCnt_r <= cmd[29:0];
        else if (tmoCnt_r != 30'h00000000)
            tmoCnt_r <= tmoCnt_r - 30'h00000001;
    end

    always_comb begin
        flagSet = 32'h00000000;
        flagSet[FLG_TMO_FIN] = tmoExpire;
        flagSet[FLG_TMO_ERR] = tmoExpire && state_r != S_IDLE;
        flagSet[FLG_END_SEQ] = selfCfgWr && !cmd[RUN_BIT] && isLast;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst)
            flagReg_r <= 32'h00000000;
        else
            flagReg_r <= flagSet | (flagReg_r & ~flagClr);
    end

    ////////////////////////////////////////////////////////////////////////////
    // data FIFO in the shared SRAM, placed right after the command region
    logic [10:0] dataBase, dataWords, rdIdx, wrIdx;
    logic [2:0]  srcSel;
    logic        fifoEn, push, pop, rdEmpty, full, empty, stream, dropOld;
    assign dataBase  = sizeWords(memCtl_r[CMD_SIZE_LSB +: 3]);
    assign dataWords = sizeWords(memCtl_r[DATA_SIZE_LSB +: 3]);
    assign stream    = memCtl_r[DATA_MODE_LSB +: 3] == MODE_STREAM;
    assign fifoEn    = fifoCfg_r[FIFO_EN_BIT];
    assign srcSel    = fifoCfg_r[SRC_LSB +: 3];
    assign push      = fifoEn && srcSel < NUM_SRC && srcIn[srcSel].valid;
    assign empty     = fifoCnt_r == 11'h000;
    assign full      = fifoCnt_r >= dataWords;
    assign pop       = apbRd && paddr == ADDR_FIFO_READ && !empty;
    assign rdEmpty   = apbRd && paddr == ADDR_FIFO_READ && empty;
    assign dropOld   = push && full && !pop && stream;
    assign rdIdx     = wrapIdx({1'b0, dataBase} + {1'b0, rdOff_r});
    assign wrIdx     = wrapIdx({1'b0, dataBase} + {1'b0, wrOff_r});
    assign fifoWord  = empty ? 32'h00000000 : mem_r[rdIdx];

    always_ff @(posedge clk) begin
        if (push && (!full || pop || stream))
            mem_r[wrIdx] <= srcIn[srcSel].data;
        else if (apbWr && paddr == ADDR_CMD_WRITE)
            mem_r[cmdWaddr_r] <= pwdata;
    end

    always_ff @(posedge clk) begin
        if (rst || !fifoEn) begin
            fifoCnt_r <= 11'h000;
            rdOff_r   <= 11'h000;
            wrOff_r   <= 11'h000;
        end else begin
            if (pop || dropOld)
                rdOff_r <= (rdOff_r + 11'h001 >= dataWords) ? 11'h000 : rdOff_r + 11'h001;
            if (push && (!full || pop || stream))
                wrOff_r <= (wrOff_r + 11'h001 >= dataWords) ? 11'h000 : wrOff_r + 11'h001;
            if (push && (!full || pop) && !pop)
                fifoCnt_r <= fifoCnt_r + 11'h001;
            else if (pop && !push)
                fifoCnt_r <= fifoCnt_r - 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_r <= 1'b0;
            udf_r <= 1'b0;
        end else begin
            ovf_r <= push && full && !pop;
            udf_r <= rdEmpty;
        end
    end

    // each FIFO flag is gated by its own mask bit
    always_comb begin
        flags.endSeq        = flagReg_r[FLG_END_SEQ];
        flags.tmoFinished   = flagReg_r[FLG_TMO_FIN];
        flags.tmoError      = flagReg_r[FLG_TMO_ERR];
        flags.fifoEmpty     = empty && mask_r[0];
        flags.fifoFull      = full && mask_r[1];
        flags.fifoThresh    = fifoCnt_r >= thres_r[10:0] && mask_r[2];
        flags.fifoOverflow  = ovf_r && mask_r[FLG_OVF];
        flags.fifoUnderflow = udf_r && mask_r[FLG_UDF];
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_wr_full_word: assert property (mmrWr.valid |-> mmrWr.data[31:24] == 8'h00 && mmrWr.addr[1:0] == 2'b00)
        else $error("sequencer write not a clean 24-bit word");
    a_wr_addr_map: assert property (exec && isWrite && !selfCfgWr
        |=> mmrWr.valid && mmrWr.addr[8:2] == $past(cmd[30:24]))
        else $error("write command address not mapped in one cycle");
    a_tmo_finish: assert property (tmoExpire |=> flagReg_r[FLG_TMO_FIN])
        else $error("timeout expiry did not set finished flag");
    a_tmo_error: assert property (tmoExpire && state_r != S_IDLE |=> flagReg_r[FLG_TMO_ERR])
        else $error("timeout error flag missing");
    a_flag_hold: assert property (flagReg_r[FLG_TMO_FIN] && !flagClr[FLG_TMO_FIN] |=> flagReg_r[FLG_TMO_FIN])
        else $error("timeout flag dropped without clear");
    a_tmo_reset: assert property (hostRunOff |=> tmoCnt_r == 30'h00000000 ##1 state_r == S_IDLE)
        else $error("timeout counter not reset by host stop");
    a_wait_stall: assert property (state_r == S_WAIT && waitCnt_r > 30'h00000001 && seqCfg_r[RUN_BIT]
        && !hostRunOff |=> state_r == S_WAIT && waitCnt_r == $past(waitCnt_r) - 30'h00000001)
        else $error("wait ended early");
    a_crc_reset: assert property (cntWrite |=> crc_r == CRC_SEED && cmdCount_r == 16'h0000)
        else $error("count write did not reset crc");
    a_udf_zero: assert property (rdEmpty |-> prdata == 32'h00000000 ##1 udf_r ##1 !udf_r || rdEmpty)
        else $error("empty read not zero or no underflow pulse");
    a_fifo_bound: assert property (fifoCnt_r <= dataWords || $changed(memCtl_r))
        else $error("fifo count beyond region size");
endmodule : acsf_sequencer

`default_nettype wire

// ---- verification/acsf_host_model.sv ----
////////////////////////////////////////
// Purpose: APB host model for the sequencer
// Assumes: pready sampled at the rising edge
// Notes:   a wait beyond 64 cycles counts a hang
////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module acsf_host_model
    import acsf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output var logic         psel,
    output var logic         penable,
    output var logic         pwrite,
    output var logic  [15:0] paddr,
    output var logic  [31:0] pwdata
);
    int   hangs = 0;
    logic lastErr;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) hangs++;
        q = prdata;
        lastErr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
    // address first, else the word lands at a stale slot
    task automatic loadCmd(input logic [10:0] at, input logic [31:0] cmd);
        logic [31:0] q;
        xfer(1'b1, ADDR_CMD_WADDR, {21'h0, at}, q);
        xfer(1'b1, ADDR_CMD_WRITE, cmd, q);
    endtask : loadCmd
endmodule : acsf_host_model
`default_nettype wire

// ---- verification/acsf_sequencer_test.sv ----
////////////////////////////////////////
// Purpose: self-checking bench of sequencer and data FIFO
// Assumes: flag mask set before FIFO flag checks
// Notes:   fixed-seed xorshift data
////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errorCnt++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module acsf_sequencer_test
    import acsf_pkg::*;
;
    logic            clk, rst, psel, penable, pwrite, pready, pslverr, seqBusy;
    logic [15:0]     paddr;
    logic [31:0]     pwdata, prdata, q, base, crc, seed = 32'h1F64;
    logic [31:0]     c [4];
    logic [6:0]      f [2];
    logic [23:0]     d [2];
    logic [2:0]      sel;
    acsf_src_t [4:0] src;
    acsf_mmr_wr_t    mmrWr;
    acsf_flags_t     flags;
    int              errorCnt = 0, samplesChecked = 0, cyc = 0;
    int              wrT [$];
    logic [47:0]     wrV [$];
    logic [47:0]     rstTab [5] = '{{ADDR_SEQ_CONFIG, SEQCFG_RST}, {ADDR_FIFO_CONFIG, FIFOCFG_RST},
        {ADDR_MEM_CTRL, MEMCTL_RST}, {ADDR_CMD_CRC, 24'h0, CRC_SEED}, {ADDR_FIFO_STAT, 32'h0}};
    acsf_sequencer uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .srcIn(src), .mmrWr, .flags, .seqBusy);
    acsf_host_model host (.clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mmrWr.valid === 1'b1) begin
            wrT.push_back(cyc);
            wrV.push_back({mmrWr.addr, mmrWr.data});
        end
    end
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] crc8(input logic [7:0] r, input logic [31:0] w);
        for (int i = 31; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ w[i]) ? CRC_POLY : 8'h00);
        return r;
    endfunction : crc8
    task automatic rd(input logic [15:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, q);
    endtask : wr
    task automatic push(input logic [2:0] s, input logic [31:0] v);
        @(posedge clk);
        src[s] <= {1'b1, v};
        @(posedge clk);
        src[s].valid <= 1'b0;
    endtask : push
    task automatic waitIdle();
        int n = 0;
        repeat (2) @(posedge clk);
        while (seqBusy !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n == 4000) begin
            errorCnt++;
            finalReport();
        end
    endtask : waitIdle
    task automatic finalReport();
        errorCnt += host.hangs;
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finalReport
    ////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        errorCnt++;
        finalReport();
    end
    initial begin
        rst = 1'b1;
        src = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rstTab[i]) begin
            rd(rstTab[i][47:32]);
            `CHK(q, rstTab[i][31:0])
        end
        rd(16'h2FF0);
        `CHK({host.lastErr, q}, 33'h1_0000_0000)
        crc = {24'h0, CRC_SEED};
        for (int i = 0; i < 2; i++) begin
            f[i] = 7'h20 | 7'(rnd() % 32);
            d[i] = 24'(rnd());
            c[i] = {1'b1, f[i], d[i]};
        end
        c[2] = {2'b00, 30'd5};
        c[3] = {1'b1, 7'h01, 24'h0};
        for (int i = 0; i < 4; i++) begin
            host.loadCmd(11'(i), c[i]);
            crc = {24'h0, crc8(crc[7:0], c[i])};
        end
        wr(ADDR_SEQ_DESC0, {5'h0, 11'd4, 5'h0, 11'd0});
        wr(ADDR_CMD_COUNT, 32'h0);
        wr(ADDR_SEQ_CONFIG, 32'h0301);
        wr(ADDR_SEQ_TRIG, 32'h0);
        waitIdle();
        `CHK(wrV.size(), 2)
        for (int i = 0; i < 2; i++) `CHK(wrV[i], {16'h2000 | (16'(f[i]) << 2), 8'h00, d[i]})
        `CHK(wrT[1] - wrT[0], 4)
        `CHK(flags.endSeq, 1'b1)
        rd(ADDR_CMD_CRC);
        `CHK(q, crc)
        rd(ADDR_SEQ_CONFIG);
        `CHK(q[0], 1'b0)
        wr(ADDR_FLAG_CLR, 32'h0003_8000);
        host.loadCmd(11'd4, {2'b01, 30'd10});
        host.loadCmd(11'd5, {2'b00, 30'd40});
        host.loadCmd(11'd6, c[3]);
        wr(ADDR_SEQ_DESC1, {5'h0, 11'd3, 5'h0, 11'd4});
        wr(ADDR_SEQ_CONFIG, 32'h1);
        wr(ADDR_SEQ_TRIG, 32'h1);
        waitIdle();
        repeat (5) @(posedge clk);
        rd(ADDR_FLAG);
        `CHK(q[17:15], 3'b111)
        wr(ADDR_FLAG_CLR, 32'h0003_0000);
        #1;
        `CHK({flags.tmoFinished, flags.tmoError, flags.endSeq}, 3'b001)
        host.loadCmd(11'd7, {2'b01, 30'h3E8});
        host.loadCmd(11'd8, {2'b00, 30'h7D0});
        wr(ADDR_SEQ_DESC2, {5'h0, 11'd2, 5'h0, 11'd7});
        wr(ADDR_SEQ_CONFIG, 32'h1);
        wr(ADDR_SEQ_TRIG, 32'h2);
        repeat (20) @(posedge clk);
        rd(ADDR_TMO_COUNT);
        `CHK(q > 32'h384 && q < 32'h3E8, 1'b1)
        wr(ADDR_SEQ_CONFIG, 32'h0);
        rd(ADDR_TMO_COUNT);
        `CHK({q, seqBusy, flags.tmoFinished}, 34'h0)
        wr(ADDR_FLAG_MASK, 32'h0C00_0007);
        wr(ADDR_FIFO_THRES, 32'd512);
        for (int m = 0; m < 2; m++) begin
            sel = 3'(rnd() % 5);
            base = rnd();
            wr(ADDR_MEM_CTRL, m ? 32'h610 : 32'h410);
            wr(ADDR_FIFO_CONFIG, {16'h0, sel, 13'h0800});
            push(3'((sel + 1) % 5), 32'hDEAD_BEEF);
            for (int i = 0; i < 513; i++) push(sel, base + i);
            #1;
            `CHK({flags.fifoOverflow, flags.fifoFull, flags.fifoThresh}, 3'b111)
            rd(ADDR_FIFO_STAT);
            `CHK(q, {5'h0, 11'd512, 16'h0})
            rd(ADDR_FIFO_READ);
            `CHK(q, base + m)
            wr(ADDR_FIFO_CONFIG, {16'h0, sel, 13'h0});
            wr(ADDR_FIFO_CONFIG, {16'h0, sel, 13'h0800});
            rd(ADDR_FIFO_READ);
            #1;
            `CHK({q, flags.fifoUnderflow, flags.fifoEmpty}, {32'h0, 2'b11})
        end
        finalReport();
    end
endmodule : acsf_sequencer_test
`default_nettype wire
